// [pbat_assertions.sv]
// pbat_assertions.sv: timing checks on the address tenure wires
// assumes one clock, sync active low reset, lines resolved by the bench
`timescale 1ns/10ps
`include "pbat_cfg.svh"
module pbat_assertions
    import pbat_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // ownership and strobes
    input wire logic primary_bus_request_n,
    input wire logic primary_bus_grant_n,
    input wire logic transfer_begin_n,
    input wire logic br_begin_oe,
    input wire logic pm_begin_oe,
    input wire logic extended_transfer_begin_n,
    input wire logic transfer_error_ack_n,
    input wire logic address_phase_ack_n,
    input wire logic address_phase_retry_n,
    // attribute drives
    input wire logic br_attr_oe,
    input wire logic pm_attr_oe,
    input wire pbat_addr_t pm_addr_o,
    input wire pbat_kind_t br_kind_o,
    input wire pbat_len_t br_len_o
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // cycles since the last extended start, saturates so old pulses fade
    logic [3:0] ext_age_q, ext_age_d;
    always_comb
    begin
        ext_age_d = ext_age_q;
        if (!extended_transfer_begin_n)
            ext_age_d = 4'h0;
        else if (ext_age_q != 4'hf)
            ext_age_d = ext_age_q + 4'h1;
    end
    // register only
    always_ff @(posedge clk)
    begin
        if (!resetn)
            ext_age_q <= 4'hf;
        else
            ext_age_q <= ext_age_d;
    end
    grant_after_req_a: assert property ($fell(primary_bus_grant_n) |->
        $past(!primary_bus_request_n, 3)) else $error("grant without request");
    grant_off_snoop_a: assert property (br_begin_oe |-> primary_bus_grant_n)
        else $error("grant during snoop");
    snoop_attrs_a: assert property (br_begin_oe && !transfer_begin_n |-> br_attr_oe &&
        br_kind_o == `PBAT_SNOOP_KIND && br_len_o == `PBAT_SNOOP_LEN)
        else $error("bad snoop start");
    one_owner_a: assert property (!(br_attr_oe && pm_attr_oe))
        else $error("two attribute drivers");
    tea_cause_a: assert property (!transfer_error_ack_n |-> ext_age_q < 4'h8)
        else $error("error ack without extended start");
    tea_pulse_a: assert property (!transfer_error_ack_n |=> transfer_error_ack_n)
        else $error("error ack too long");
    ack_follows_a: assert property ($fell(transfer_begin_n) && pm_begin_oe |->
        ##[1:8] !address_phase_ack_n) else $error("no ack after start");
    float_after_a: assert property (!address_phase_ack_n |-> ##[1:4] !pm_attr_oe)
        else $error("master kept driving");
    retry_place_a: assert property (!address_phase_retry_n |->
        $past(!address_phase_ack_n) || $past(!address_phase_ack_n, 2))
        else $error("retry out of place");
    start_ok_a: assert property (pm_begin_oe && !transfer_begin_n |-> pm_attr_oe &&
        $past(!primary_bus_grant_n) && pm_addr_o[2:0] == 3'h0)
        else $error("bad master start");
    // main scenarios reached
    snoop_c: cover property (br_begin_oe && !transfer_begin_n);
    retry_c: cover property (!address_phase_retry_n);
    tea_c: cover property (!transfer_error_ack_n);
endmodule

// [pbat_bridge.sv]
// pbat_bridge.sv: bridge end of the processor address tenure
// assumes master end on same clk; control pins resynchronised via pbat_sync
`timescale 1ns/10ps
`include "pbat_cfg.svh"
module pbat_bridge
    import pbat_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // processor bus side
    pbat_if.bridge bus,
    // user side: snoop request from the pci path
    input wire logic snoop_req,
    input wire pbat_addr_t snoop_addr,
    input wire logic copyback_req,
    input wire pbat_addr_t copyback_addr,
    output logic snoop_done,
    // user side: policy inputs
    input wire logic tea_enable,
    input wire logic retry_req,
    // user side: captured master tenure
    output logic tenure_valid,
    output pbat_addr_t tenure_addr,
    output pbat_kind_t tenure_kind,
    output pbat_len_t tenure_len,
    output logic tenure_burst,
    output logic tenure_retried
);
    // synchronised pins, active low reset value 1
    logic req_n_s, begin_n_s, xbegin_n_s;
    pbat_sync #(.W(3), .RST(3'h7)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin({bus.primary_bus_request_n, bus.transfer_begin_n, bus.extended_transfer_begin_n}),
        .synced({req_n_s, begin_n_s, xbegin_n_s})
    );
    // attribute lines: multi-bit held stable while start is low, so a
    // single resync is not needed; sampled once start is seen
    pbat_state_e state_q, state_d;
    logic grant_n_q, grant_n_d;
    logic begin_n_q, begin_n_d, attr_oe_q, attr_oe_d;
    logic ack_n_q, ack_n_d, retry_n_q, retry_n_d, tea_n_q, tea_n_d;
    pbat_addr_t addr_q, addr_d;
    pbat_kind_t kind_q, kind_d;
    pbat_len_t len_q, len_d;
    logic burst_n_q, burst_n_d;
    logic done_q, done_d, tv_q, tv_d, tr_q, tr_d;
    logic [1:0] wait_q, wait_d;
    logic xprev_q, xprev_d;
    // next state of the tenure engine
    always_comb
    begin
        state_d = state_q;
        grant_n_d = grant_n_q;
        begin_n_d = 1'b1;
        attr_oe_d = attr_oe_q;
        ack_n_d = 1'b1;
        retry_n_d = 1'b1;
        tea_n_d = 1'b1;
        addr_d = addr_q;
        kind_d = kind_q;
        len_d = len_q;
        burst_n_d = burst_n_q;
        done_d = 1'b0;
        tv_d = 1'b0;
        tr_d = 1'b0;
        wait_d = wait_q;
        xprev_d = xbegin_n_s;
        if (!xbegin_n_s && xprev_q && tea_enable)
            tea_n_d = 1'b0;
        case (state_q)
            PBAT_IDLE:
            begin
                // snoop has priority: keeps grant negated while we own bus
                if (snoop_req || copyback_req)
                begin
                    state_d = PBAT_SNOOP;
                    grant_n_d = 1'b1;
                    begin_n_d = 1'b0;
                    attr_oe_d = 1'b1;
                    addr_d = snoop_req ? snoop_addr : copyback_addr;
                    kind_d = `PBAT_SNOOP_KIND;
                    len_d = `PBAT_SNOOP_LEN;
                    burst_n_d = 1'b1;
                    wait_d = `PBAT_ACK_DELAY;
                end
                else if (!req_n_s)
                begin
                    state_d = PBAT_GRANT;
                    grant_n_d = 1'b0;
                end
            end
            PBAT_GRANT:
            begin
                if (!begin_n_s)
                begin
                    state_d = PBAT_ADDR;
                    grant_n_d = 1'b1;
                    addr_d = bus.phys_address_bus;
                    kind_d = bus.transfer_kind;
                    len_d = bus.transfer_length;
                    burst_n_d = bus.burst_flag_n;
                    wait_d = `PBAT_ACK_DELAY;
                end
                else if (req_n_s)
                begin
                    // request withdrawn before start
                    state_d = PBAT_IDLE;
                    grant_n_d = 1'b1;
                end
            end
            PBAT_ADDR:
            begin
                if (wait_q != 2'h0)
                    wait_d = wait_q - 2'h1;
                else
                begin
                    ack_n_d = 1'b0;
                    state_d = PBAT_RELEASE;
                    tv_d = !retry_req;
                    tr_d = retry_req;
                end
            end
            PBAT_SNOOP:
            begin
                if (wait_q != 2'h0)
                    wait_d = wait_q - 2'h1;
                else
                begin
                    ack_n_d = 1'b0;
                    done_d = 1'b1;
                    state_d = PBAT_RELEASE;
                end
            end
            PBAT_RELEASE:
            begin
                // bus floated the cycle after ack
                attr_oe_d = 1'b0;
                // retry in the cycle after ack
                retry_n_d = !tr_q;
                state_d = PBAT_IDLE;
            end
            default:
            begin
                state_d = PBAT_IDLE;
                grant_n_d = 1'b1;
                attr_oe_d = 1'b0;
            end
        endcase
    end
    // register the tenure engine
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q <= PBAT_IDLE;
            grant_n_q <= 1'b1;
            begin_n_q <= 1'b1;
            attr_oe_q <= 1'b0;
            ack_n_q <= 1'b1;
            retry_n_q <= 1'b1;
            tea_n_q <= 1'b1;
            addr_q <= '0;
            kind_q <= '0;
            len_q <= '0;
            burst_n_q <= 1'b1;
            done_q <= 1'b0;
            tv_q <= 1'b0;
            tr_q <= 1'b0;
            wait_q <= 2'h0;
            xprev_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            grant_n_q <= grant_n_d;
            begin_n_q <= begin_n_d;
            attr_oe_q <= attr_oe_d;
            ack_n_q <= ack_n_d;
            retry_n_q <= retry_n_d;
            tea_n_q <= tea_n_d;
            addr_q <= addr_d;
            kind_q <= kind_d;
            len_q <= len_d;
            burst_n_q <= burst_n_d;
            done_q <= done_d;
            tv_q <= tv_d;
            tr_q <= tr_d;
            wait_q <= wait_d;
            xprev_q <= xprev_d;
        end
    end
    // strobe pins driven with low meaning asserted, drive enables with high
    assign bus.primary_bus_grant_n = grant_n_q;
    assign bus.br_begin_n_o = begin_n_q;
    assign bus.br_begin_oe = attr_oe_q;
    assign bus.br_addr_o = addr_q;
    assign bus.br_kind_o = kind_q;
    assign bus.br_len_o = len_q;
    assign bus.br_burst_n_o = burst_n_q;
    assign bus.br_attr_oe = attr_oe_q;
    assign bus.address_phase_ack_n = ack_n_q;
    assign bus.address_phase_retry_n = retry_n_q;
    assign bus.transfer_error_ack_n = tea_n_q;
    assign snoop_done = done_q;
    assign tenure_valid = tv_q;
    assign tenure_retried = tr_q;
    assign tenure_addr = addr_q;
    assign tenure_kind = kind_q;
    assign tenure_len = len_q;
    assign tenure_burst = !burst_n_q;
endmodule

// [pbat_cfg.svh]
// pbat_cfg.svh: constants for the processor bus address tenure link
// assumes inclusion by the package and both end modules
`ifndef PBAT_CFG_SVH
`define PBAT_CFG_SVH
`define PBAT_ADDR_W 32
`define PBAT_KIND_W 5
`define PBAT_LEN_W 3
// address bits below a double-word
`define PBAT_DW_LSB 3
// snoop broadcast attributes
`define PBAT_SNOOP_KIND 5'h0a
`define PBAT_SNOOP_LEN 3'h2
// cycles the bridge waits before acknowledging a tenure
`define PBAT_ACK_DELAY 2'h1
`endif

// [pbat_if.sv]
// pbat_if.sv: address tenure wires between bridge and processor master
// assumes the testbench resolves shared lines from the enables
`timescale 1ns/10ps
interface pbat_if;
    import pbat_pkg::*;
    // bus ownership, active low
    logic primary_bus_request_n;
    logic primary_bus_grant_n;
    // start strobes, active low, shared start has per-end drives
    logic br_begin_n_o, br_begin_oe, pm_begin_n_o, pm_begin_oe, transfer_begin_n;
    logic extended_transfer_begin_n;
    logic transfer_error_ack_n;
    // shared address tenure lines
    pbat_addr_t br_addr_o, pm_addr_o, phys_address_bus;
    pbat_kind_t br_kind_o, pm_kind_o, transfer_kind;
    pbat_len_t br_len_o, pm_len_o, transfer_length;
    logic br_burst_n_o, pm_burst_n_o, burst_flag_n;
    logic br_attr_oe, pm_attr_oe;
    // tenure end, driven by bridge
    logic address_phase_ack_n;
    logic address_phase_retry_n;
    modport bridge (
        input primary_bus_request_n, transfer_begin_n, extended_transfer_begin_n,
        input phys_address_bus, transfer_kind, transfer_length, burst_flag_n,
        output primary_bus_grant_n, br_begin_n_o, br_begin_oe, transfer_error_ack_n,
        output br_addr_o, br_kind_o, br_len_o, br_burst_n_o, br_attr_oe,
        output address_phase_ack_n, address_phase_retry_n
    );
    modport master (
        input primary_bus_grant_n, transfer_begin_n, transfer_error_ack_n,
        input phys_address_bus, transfer_kind, transfer_length, burst_flag_n,
        input address_phase_ack_n, address_phase_retry_n,
        output primary_bus_request_n, pm_begin_n_o, pm_begin_oe, extended_transfer_begin_n,
        output pm_addr_o, pm_kind_o, pm_len_o, pm_burst_n_o, pm_attr_oe
    );
endinterface

// [pbat_master.sv]
// pbat_master.sv: processor master end of the address tenure
// assumes bridge end on same clk; bridge pins resynchronised here
`timescale 1ns/10ps
`include "pbat_cfg.svh"
module pbat_master
    import pbat_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // processor bus side
    pbat_if.master bus,
    // user side: request a tenure
    input wire logic cmd_valid,
    input wire pbat_addr_t cmd_addr,
    input wire pbat_kind_t cmd_kind,
    input wire pbat_len_t cmd_len,
    input wire logic cmd_burst,
    input wire logic cmd_ext,
    output logic cmd_ready,
    output logic cmd_done,
    output logic cmd_error
);
    logic grant_n_s, ack_n_s, retry_n_s, tea_n_s;
    pbat_sync #(.W(4), .RST(4'hf)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin({bus.primary_bus_grant_n, bus.address_phase_ack_n,
              bus.address_phase_retry_n, bus.transfer_error_ack_n}),
        .synced({grant_n_s, ack_n_s, retry_n_s, tea_n_s})
    );
    typedef enum logic [3:0] {
        PM_IDLE = 4'h1, PM_REQ = 4'h2, PM_TEN = 4'h4, PM_CHK = 4'h8
    } pbat_pm_e;
    pbat_pm_e st_q, st_d;
    logic req_n_q, req_n_d, beg_n_q, beg_n_d, oe_q, oe_d, x_n_q, x_n_d;
    pbat_addr_t a_q, a_d;
    pbat_kind_t k_q, k_d;
    pbat_len_t l_q, l_d;
    logic b_n_q, b_n_d, done_q, done_d, err_q, err_d, rdy_q, rdy_d;
    // master sequence
    always_comb
    begin
        st_d = st_q;
        req_n_d = req_n_q;
        beg_n_d = 1'b1;
        oe_d = oe_q;
        x_n_d = 1'b1;
        a_d = a_q;
        k_d = k_q;
        l_d = l_q;
        b_n_d = b_n_q;
        done_d = 1'b0;
        err_d = 1'b0;
        rdy_d = 1'b0;
        case (st_q)
            PM_IDLE:
            begin
                // error ack ends an extended start
                err_d = !tea_n_s;
                if (cmd_valid && cmd_ext)
                begin
                    // unsupported extended start, error reported only on the ack
                    x_n_d = 1'b0;
                    rdy_d = 1'b1;
                end
                else if (cmd_valid)
                begin
                    st_d = PM_REQ;
                    req_n_d = 1'b0;
                    rdy_d = 1'b1;
                    a_d = {cmd_addr[`PBAT_ADDR_W-1:`PBAT_DW_LSB], `PBAT_DW_LSB'h0};
                    k_d = cmd_kind;
                    l_d = cmd_len;
                    b_n_d = !cmd_burst;
                end
            end
            PM_REQ:
            begin
                if (!grant_n_s)
                begin
                    st_d = PM_TEN;
                    req_n_d = 1'b1;
                    beg_n_d = 1'b0;
                    oe_d = 1'b1;
                end
            end
            PM_TEN:
            begin
                if (!ack_n_s)
                begin
                    oe_d = 1'b0;
                    st_d = PM_CHK;
                end
            end
            PM_CHK:
            begin
                if (!retry_n_s)
                begin
                    st_d = PM_REQ;
                    req_n_d = 1'b0;
                end
                else
                begin
                    done_d = 1'b1;
                    st_d = PM_IDLE;
                end
            end
            default:
            begin
                st_d = PM_IDLE;
                req_n_d = 1'b1;
                oe_d = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_q <= PM_IDLE;
            req_n_q <= 1'b1;
            beg_n_q <= 1'b1;
            oe_q <= 1'b0;
            x_n_q <= 1'b1;
            a_q <= '0;
            k_q <= '0;
            l_q <= '0;
            b_n_q <= 1'b1;
            done_q <= 1'b0;
            err_q <= 1'b0;
            rdy_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            req_n_q <= req_n_d;
            beg_n_q <= beg_n_d;
            oe_q <= oe_d;
            x_n_q <= x_n_d;
            a_q <= a_d;
            k_q <= k_d;
            l_q <= l_d;
            b_n_q <= b_n_d;
            done_q <= done_d;
            err_q <= err_d;
            rdy_q <= rdy_d;
        end
    end
    // kind, length, burst driven while owning
    assign bus.primary_bus_request_n = req_n_q;
    assign bus.pm_begin_n_o = beg_n_q;
    assign bus.pm_begin_oe = oe_q;
    assign bus.pm_attr_oe = oe_q;
    assign bus.pm_addr_o = a_q;
    assign bus.pm_kind_o = k_q;
    assign bus.pm_len_o = l_q;
    assign bus.pm_burst_n_o = b_n_q;
    assign bus.extended_transfer_begin_n = x_n_q;
    assign cmd_ready = rdy_q;
    assign cmd_done = done_q;
    assign cmd_error = err_q;
endmodule

// [pbat_pkg.sv]
// pbat_pkg.sv: shared types for both ends of the address tenure link
// assumes pbat_cfg.svh is on the include path
`include "pbat_cfg.svh"
package pbat_pkg;
    typedef logic [`PBAT_ADDR_W-1:0] pbat_addr_t;
    typedef logic [`PBAT_KIND_W-1:0] pbat_kind_t;
    typedef logic [`PBAT_LEN_W-1:0] pbat_len_t;
    // bridge tenure states
    typedef enum logic [4:0] {
        PBAT_IDLE = 5'h01,
        PBAT_GRANT = 5'h02,
        PBAT_ADDR = 5'h04,
        PBAT_SNOOP = 5'h08,
        PBAT_RELEASE = 5'h10
    } pbat_state_e;
endpackage

// [pbat_sync.sv]
// pbat_sync.sv: two flop synchroniser for pins from the other party
// assumes one clock, synchronous active low reset
`timescale 1ns/10ps
module pbat_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pin side and synced side
    input wire logic [W-1:0] pin,
    output logic [W-1:0] synced
);
    logic [W-1:0] meta_q, meta_d, sync_q, sync_d;
    // first stage feeds only the second
    always_comb
    begin
        meta_d = pin;
        sync_d = meta_q;
    end
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta_q <= RST;
            sync_q <= RST;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end
    assign synced = sync_q;
endmodule

// [testbench.sv]
// testbench.sv: both tenure ends joined, driven from their user sides
// assumes pbat_pkg, pbat_if and both ends compiled before this file
`timescale 1ns/10ps
`include "pbat_cfg.svh"
module testbench import pbat_pkg::*;;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    // bridge user side
    logic snoop_req = 1'b0, copyback_req = 1'b0, tea_enable = 1'b1, retry_req = 1'b0;
    pbat_addr_t snoop_addr = '0, copyback_addr = '0, tenure_addr;
    logic snoop_done, tenure_valid, tenure_burst, tenure_retried;
    pbat_kind_t tenure_kind;
    pbat_len_t tenure_len;
    // master user side
    logic cmd_valid = 1'b0, cmd_burst = 1'b0, cmd_ext = 1'b0;
    logic cmd_ready, cmd_done, cmd_error;
    pbat_addr_t cmd_addr = '0;
    pbat_kind_t cmd_kind = '0;
    pbat_len_t cmd_len = '0;
    // scoreboard
    int bad_count = 0, n_compared = 0;
    int n_ten = 0, n_rty = 0, n_tea = 0, n_snp = 0, n_cb = 0;
    logic [31:0] t_addr, t_attr, s_addr, s_attr;
    logic got_err;
    always #5 clk = ~clk;
    pbat_if bus_if ();
    // shared lines: bridge drive, else master drive, else pulled high
    assign bus_if.transfer_begin_n = bus_if.br_begin_oe ? bus_if.br_begin_n_o :
        bus_if.pm_begin_oe ? bus_if.pm_begin_n_o : 1'b1;
    assign bus_if.phys_address_bus = bus_if.br_attr_oe ? bus_if.br_addr_o :
        bus_if.pm_attr_oe ? bus_if.pm_addr_o : '1;
    assign bus_if.transfer_kind = bus_if.br_attr_oe ? bus_if.br_kind_o :
        bus_if.pm_attr_oe ? bus_if.pm_kind_o : '1;
    assign bus_if.transfer_length = bus_if.br_attr_oe ? bus_if.br_len_o :
        bus_if.pm_attr_oe ? bus_if.pm_len_o : '1;
    assign bus_if.burst_flag_n = bus_if.br_attr_oe ? bus_if.br_burst_n_o :
        bus_if.pm_attr_oe ? bus_if.pm_burst_n_o : 1'b1;
    pbat_bridge u_pbat_bridge (.clk, .resetn, .bus(bus_if), .snoop_req, .snoop_addr,
        .copyback_req, .copyback_addr, .snoop_done, .tea_enable, .retry_req,
        .tenure_valid, .tenure_addr, .tenure_kind, .tenure_len, .tenure_burst,
        .tenure_retried);
    pbat_master u_pbat_master (.clk, .resetn, .bus(bus_if), .cmd_valid, .cmd_addr,
        .cmd_kind, .cmd_len, .cmd_burst, .cmd_ext, .cmd_ready, .cmd_done, .cmd_error);
    pbat_assertions u_pbat_assertions (.clk, .resetn,
        .primary_bus_request_n(bus_if.primary_bus_request_n),
        .primary_bus_grant_n(bus_if.primary_bus_grant_n),
        .transfer_begin_n(bus_if.transfer_begin_n), .br_begin_oe(bus_if.br_begin_oe),
        .pm_begin_oe(bus_if.pm_begin_oe),
        .extended_transfer_begin_n(bus_if.extended_transfer_begin_n),
        .transfer_error_ack_n(bus_if.transfer_error_ack_n),
        .address_phase_ack_n(bus_if.address_phase_ack_n),
        .address_phase_retry_n(bus_if.address_phase_retry_n),
        .br_attr_oe(bus_if.br_attr_oe), .pm_attr_oe(bus_if.pm_attr_oe),
        .pm_addr_o(bus_if.pm_addr_o), .br_kind_o(bus_if.br_kind_o),
        .br_len_o(bus_if.br_len_o));
    // monitor: captured tenures, retries, error acks, bridge drives
    always @(posedge clk)
    begin
        if (tenure_valid === 1'b1)
        begin
            n_ten++;
            t_addr = tenure_addr;
            t_attr = {23'h0, tenure_kind, tenure_len, tenure_burst};
        end
        if (tenure_retried === 1'b1)
            n_rty++;
        if (bus_if.transfer_error_ack_n === 1'b0)
            n_tea++;
        if (bus_if.br_begin_oe === 1'b1 && bus_if.transfer_begin_n === 1'b0)
        begin
            n_snp++;
            s_addr = bus_if.phys_address_bus;
            s_attr = {24'h0, bus_if.transfer_kind, bus_if.transfer_length};
        end
        if (copyback_req && bus_if.br_attr_oe === 1'b1)
            n_cb += (bus_if.phys_address_bus === copyback_addr);
    end
    // verdict and end of run
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // a bounded wait ran out
    task automatic tmo(input string nm);
        bad_count++;
        $display("mismatch %s expected done seen timeout", nm);
        stop_test();
    endtask
    // one comparison
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one master command; lim 300 must end, a shorter lim only watches
    task automatic run_cmd(input pbat_addr_t a, input pbat_kind_t k, input pbat_len_t l,
        input logic b, input logic x, input logic r, input int lim);
        int i;
        @(posedge clk);
        #1;
        {cmd_addr, cmd_kind, cmd_len, cmd_burst, cmd_ext} = {a, k, l, b, x};
        retry_req = r;
        cmd_valid = 1'b1;
        // outputs looked at just after the edge, once settled
        for (i = 0; i < 50 && cmd_ready !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        if (i == 50)
            tmo("cmd_ready");
        cmd_valid = 1'b0;
        // retry asked once only, so the repeat can finish
        for (i = 0; i < lim && cmd_done !== 1'b1 && cmd_error !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
            if (tenure_retried === 1'b1)
                retry_req = 1'b0;
        end
        if (i == lim && lim == 300)
            tmo("cmd_done");
        got_err = cmd_error;
    endtask
    pbat_addr_t ta [3] = '{32'h0000_1004, 32'h8000_0ff8, 32'hffff_ffff};
    pbat_kind_t tk [3] = '{5'h02, 5'h0e, 5'h1f};
    pbat_len_t tl [3] = '{3'h0, 3'h2, 3'h7};
    initial
    begin
        int j, n0, r0;
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (2) @(posedge clk);
        // single and burst tenures, low address bits dropped
        for (j = 0; j < 3; j++)
        begin
            n0 = n_ten;
            run_cmd(ta[j], tk[j], tl[j], j != 0, 1'b0, 1'b0, 300);
            chk("tenures", n0 + 1, n_ten);
            chk("address", {ta[j][31:3], 3'h0}, t_addr);
            chk("attributes", {23'h0, tk[j], tl[j], j != 0}, t_attr);
            chk("error", 32'h0, {31'h0, got_err});
        end
        // retried tenure is repeated
        n0 = n_ten;
        r0 = n_rty;
        run_cmd(32'h0000_2010, 5'h06, 3'h4, 1'b0, 1'b0, 1'b1, 300);
        chk("retries", r0 + 1, n_rty);
        chk("repeat tenures", n0 + 1, n_ten);
        // extended start answered with error ack
        n0 = n_tea;
        run_cmd(32'h0000_3000, 5'h02, 3'h0, 1'b0, 1'b1, 1'b0, 300);
        chk("ext error", 32'h1, {31'h0, got_err});
        chk("error acks", n0 + 1, n_tea);
        // snoop broadcast with bridge attributes
        n0 = n_snp;
        snoop_addr = 32'h0012_3458;
        snoop_req = 1'b1;
        for (j = 0; j < 100 && snoop_done !== 1'b1; j++)
        begin
            @(posedge clk);
            #1;
        end
        if (j == 100)
            tmo("snoop_done");
        snoop_req = 1'b0;
        chk("snoop seen", 32'h1, {31'h0, n_snp > n0});
        chk("snoop address", 32'h0012_3458, s_addr);
        chk("snoop attrs", {24'h0, `PBAT_SNOOP_KIND, `PBAT_SNOOP_LEN}, s_attr);
        // copy-back address driven by the bridge
        // let the snoop done pulse pass first
        @(posedge clk);
        #1 copyback_addr = 32'h00ab_cde0;
        copyback_req = 1'b1;
        for (j = 0; j < 100 && snoop_done !== 1'b1; j++)
        begin
            @(posedge clk);
            #1;
        end
        if (j == 100)
            tmo("copyback done");
        copyback_req = 1'b0;
        chk("copyback drive", 32'h1, {31'h0, n_cb > 0});
        // error ack disabled: none may appear
        repeat (20) @(posedge clk);
        #1 tea_enable = 1'b0;
        n0 = n_tea;
        run_cmd(32'h0000_4000, 5'h02, 3'h0, 1'b0, 1'b1, 1'b0, 30);
        chk("masked error acks", n0, n_tea);
        chk("masked error", 32'h0, {31'h0, got_err});
        stop_test();
    end
endmodule
